// >>> common/dma_addr_pkg.sv
// Package: register map, field layout and modes of the address control block
package dma_addr_pkg;
   // Register byte offsets
   localparam logic [7:0]  OFS_ADDR_CTRL   = 8'h00;
   localparam logic [7:0]  OFS_SRC_ADDR    = 8'h04;
   localparam logic [7:0]  OFS_DST_ADDR    = 8'h08;
   localparam logic [7:0]  OFS_OFFSET      = 8'h0c;
   localparam logic [7:0]  OFS_CHAN_CTRL   = 8'h10;
   localparam logic [7:0]  OFS_BLOCK_SIZE  = 8'h14;
   // Address control field positions
   localparam int          POS_SINGLE_MODE = 31;
   localparam int          POS_DIRECTION   = 30;
   localparam int          POS_AREA_SEL    = 24;
   localparam int          POS_SRC_MODE    = 20;
   localparam int          POS_DST_MODE    = 16;
   localparam int          POS_SRC_OVF_IE  = 15;
   localparam int          POS_SRC_AREA    = 8;
   // Writable and reserved bits of the address control word
   localparam logic [31:0] ADDR_CTRL_WMASK = 32'hc333_9f00;
   localparam logic [31:0] ADDR_CTRL_RSVD  = 32'h00cc_6000;
   // Channel control field positions
   localparam int          POS_ENABLE      = 0;
   localparam int          POS_END_FLAG    = 1;
   localparam int          POS_ACC_SIZE    = 2;
   localparam int          POS_BLOCK_MODE  = 4;
   // Reset values
   localparam logic [31:0] RST_WORD        = 32'h0000_0000;
   localparam logic [15:0] RST_BLOCK       = 16'h0000;
   // Largest area code: 2^(26+1) bytes is 128 Mbytes
   localparam logic [4:0]  AREA_CODE_MAX   = 5'h1a;
   // Buffer shape: source, destination and size per access
   localparam int          REC_W           = 66;
   localparam int          BUF_DEPTH       = 2;

   typedef enum logic [1:0] {
      UPD_FIXED  = 2'h0,
      UPD_OFFSET = 2'h1,
      UPD_INC    = 2'h2,
      UPD_DEC    = 2'h3
   } upd_mode_t;

   typedef enum logic [1:0] {
      AREA_SRC  = 2'h0,
      AREA_DST  = 2'h1,
      AREA_NONE = 2'h2,
      AREA_BAD  = 2'h3
   } area_sel_t;

   typedef enum logic [1:0] {
      SIZE_BYTE = 2'h0,
      SIZE_WORD = 2'h1,
      SIZE_LONG = 2'h2
   } acc_size_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_RUN   = 2'b01,
      ST_DEFER = 2'b11
   } chan_state_t;
endpackage : dma_addr_pkg

// >>> rtl/rec_buffer.sv
// Two-entry valid/ready buffer for access records
`timescale 1ns/100ps
module rec_buffer
   import dma_addr_pkg::*;
#(
   parameter int W = REC_W
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   typedef struct packed {
      logic [BUF_DEPTH-1:0][W-1:0] mem;
      logic                        wr_ptr;
      logic                        rd_ptr;
      logic [1:0]                  count;
   } buf_t;

   buf_t buf_reg;
   buf_t buf_next;
   logic push;
   logic pop;

   // Handshakes; ready drops when both entries hold data
   assign in_ready_o  = (buf_reg.count != 2'h2);
   assign out_valid_o = (buf_reg.count != 2'h0);
   assign out_data_o  = buf_reg.mem[buf_reg.rd_ptr];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   // Pointer and count update
   always_comb begin
      buf_next = buf_reg;
      if (push) begin
         buf_next.mem[buf_reg.wr_ptr] = in_data_i;
         buf_next.wr_ptr = ~buf_reg.wr_ptr;
      end
      if (pop) begin
         buf_next.rd_ptr = ~buf_reg.rd_ptr;
      end
      case ({push, pop})
         2'b10:   buf_next.count = buf_reg.count + 2'h1;
         2'b01:   buf_next.count = buf_reg.count - 2'h1;
         default: buf_next.count = buf_reg.count;
      endcase
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         buf_reg <= '0;
      end else begin
         buf_reg <= buf_next;
      end
   end

   a_buf_no_overrun: assert property (@(posedge clk_i) disable iff (rst_i)
      buf_reg.count <= 2'h2)
      else $error("buffer count above depth");
endmodule : rec_buffer

// >>> rtl/dma_address_update_control.sv
// DMA channel address update control with Wishbone register slave
// Notes on behaviour
// RULE_01 - Area select 01 destination, 10 none, 11 prohibited
// RULE_02 - Area select 00 puts area on source
// RULE_03 - Reserved control bits read zero, ignore writes
// RULE_04 - Source mode 00 fixed, 01 adds offset
// RULE_05 - Source mode 10/11 steps up/down by size
// RULE_06 - Single mode: unselected source ignores mode
// RULE_07 - Destination mode 00 fixed, 01 adds offset
// RULE_08 - Destination mode 10/11 steps by size
// RULE_09 - Single mode: unselected destination ignores mode
// RULE_10 - Source area overflow stops channel, sets flag
// RULE_11 - Block mode defers overflow stop to block end
// RULE_12 - Re-enable resumes from the halted state
// RULE_13 - Overflow enable ignored without source area
// RULE_14 - Overflow enable gates the overflow request
// RULE_15 - Area keeps upper bits, wraps low bits
// RULE_16 - Single mode direction picks source or destination
// RULE_17 - Offset modes use the programmed offset register
`timescale 1ns/100ps
module dma_address_update_control
   import dma_addr_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   output logic             xfer_valid_o,
   input  wire logic        xfer_ready_i,
   output logic [31:0]      xfer_src_o,
   output logic [31:0]      xfer_dst_o,
   output logic [1:0]       xfer_size_o,
   output logic             src_block_area_o,
   output logic             dst_block_area_o,
   output logic             end_status_o
);
   typedef struct packed {
      logic [31:0] addr_ctrl;
      logic [31:0] src;
      logic [31:0] dst;
      logic [31:0] offset;
      logic        enable;
      logic        end_flag;
      logic [1:0]  acc_size;
      logic        block_mode;
      logic [15:0] block_size;
      logic [15:0] block_cnt;
      chan_state_t state;
      logic        ack;
      logic [31:0] rdata;
   } ctl_t;

   ctl_t ctl_reg;
   ctl_t ctl_next;

   // Byte-lane merge of a bus write
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   // Low-bit mask of an extended area; code 0 means no area
   function automatic logic [31:0] area_mask(input logic [4:0] code);
      logic [5:0] sh;
      sh = 6'h00;
      if (code == 5'h00) begin
         return 32'hffff_ffff;
      end
      sh = (code > AREA_CODE_MAX) ? {1'b0, AREA_CODE_MAX} + 6'h01
                                  : {1'b0, code} + 6'h01;
      return (32'h0000_0001 << sh) - 32'h0000_0001;
   endfunction : area_mask

   // Step of one access; an unused size code steps as longword
   function automatic logic [31:0] step(input logic [1:0] size);
      case (size)
         SIZE_BYTE: return 32'h0000_0001;
         SIZE_WORD: return 32'h0000_0002;
         default:   return 32'h0000_0004;
      endcase
   endfunction : step

   // Raw next address for one update mode
   function automatic logic [31:0] upd_addr(input logic [31:0] addr,
                                            input logic [1:0]  mode,
                                            input logic [1:0]  size,
                                            input logic [31:0] ofs);
      case (mode)
         UPD_FIXED:  return addr;
         UPD_OFFSET: return addr + ofs;
         UPD_INC:    return addr + step(size);
         default:    return addr - step(size);
      endcase
   endfunction : upd_addr

   logic        bus_req;
   logic        bus_wr;
   logic        single_mode;
   logic        direction;
   logic [1:0]  area_sel;
   logic [1:0]  src_mode;
   logic [1:0]  dst_mode;
   logic        src_ovf_ie;
   logic [4:0]  src_area;
   logic        src_active;
   logic        dst_active;
   logic        area_set;
   logic [31:0] src_mask;
   logic [31:0] src_raw;
   logic [31:0] src_upd;
   logic [31:0] dst_upd;
   logic        src_ovf;
   logic        ovf_irq;
   logic        block_end;
   logic [15:0] block_len;
   logic        push;
   logic        buf_ready;
   logic        stop;
   logic [31:0] wmerge;
   logic [REC_W-1:0] rec_out;

   // Field views of the address control word
   assign single_mode = ctl_reg.addr_ctrl[POS_SINGLE_MODE];
   assign direction   = ctl_reg.addr_ctrl[POS_DIRECTION];
   assign area_sel    = ctl_reg.addr_ctrl[POS_AREA_SEL +: 2];
   assign src_mode    = ctl_reg.addr_ctrl[POS_SRC_MODE +: 2];
   assign dst_mode    = ctl_reg.addr_ctrl[POS_DST_MODE +: 2];
   assign src_ovf_ie  = ctl_reg.addr_ctrl[POS_SRC_OVF_IE];
   assign src_area    = ctl_reg.addr_ctrl[POS_SRC_AREA +: 5];

   // RULE_16 direction picks address
   // RULE_06 unselected source frozen
   // RULE_09 unselected destination frozen
   assign src_active  = !(single_mode && direction);
   assign dst_active  = !(single_mode && !direction);

   // RULE_01 area select decode
   // RULE_02 source area at 00
   // A prohibited 11 code selects no area at all
   assign src_block_area_o = (area_sel == AREA_SRC);
   assign dst_block_area_o = (area_sel == AREA_DST);

   // RULE_04 source fixed or offset
   // RULE_05 source step by size
   // RULE_17 programmed offset used
   assign src_raw  = upd_addr(ctl_reg.src, src_mode, ctl_reg.acc_size,
                              ctl_reg.offset);
   assign src_mask = area_mask(src_area);
   assign area_set = (src_area != 5'h00);
   // RULE_15 upper bits held
   assign src_upd  = (ctl_reg.src & ~src_mask) | (src_raw & src_mask);
   // Overflow shows as a carry or borrow out of the masked low bits
   assign src_ovf  = area_set && (((src_raw ^ ctl_reg.src) & ~src_mask)
                                  != 32'h0000_0000);

   // RULE_07 destination fixed or offset
   // RULE_08 destination step by size
   assign dst_upd = upd_addr(ctl_reg.dst, dst_mode, ctl_reg.acc_size,
                             ctl_reg.offset);

   // One access record leaves each cycle the channel is enabled and out of ST_IDLE and the buffer has room
   assign push      = (ctl_reg.state != ST_IDLE) && ctl_reg.enable
                      && buf_ready;
   // RULE_13 enable needs an area
   // RULE_14 enable gates request
   assign ovf_irq   = push && src_active && src_ovf && src_ovf_ie;
   assign block_len = (ctl_reg.block_size == 16'h0000) ? 16'h0001
                                                       : ctl_reg.block_size;
   assign block_end = push && ctl_reg.block_mode
                      && (ctl_reg.block_cnt + 16'h0001 >= block_len);
   // RULE_10 overflow halts channel
   // RULE_11 block mode defers halt
   assign stop = (ovf_irq && (!ctl_reg.block_mode || block_end))
                 || ((ctl_reg.state == ST_DEFER) && block_end);

   assign bus_req = wb_cyc_i && wb_stb_i && !ctl_reg.ack;
   assign bus_wr  = bus_req && wb_we_i;

   // Next state: engine first, bus writes after, hardware events last
   always_comb begin
      ctl_next     = ctl_reg;
      ctl_next.ack = bus_req;
      wmerge       = 32'h0000_0000;
      if (push) begin
         if (src_active) begin
            ctl_next.src = src_upd;
         end
         if (dst_active) begin
            ctl_next.dst = dst_upd;
         end
         ctl_next.block_cnt = block_end ? 16'h0000
                                        : ctl_reg.block_cnt + 16'h0001;
      end
      // Count runs only in block mode, so a first block is never short
      if (!ctl_reg.block_mode) begin
         ctl_next.block_cnt = 16'h0000;
      end
      // Read data; unmapped offsets answer zero
      case (wb_adr_i)
         // RULE_03 reserved read zero
         OFS_ADDR_CTRL:  ctl_next.rdata = ctl_reg.addr_ctrl
                                          & ADDR_CTRL_WMASK;
         OFS_SRC_ADDR:   ctl_next.rdata = ctl_reg.src;
         OFS_DST_ADDR:   ctl_next.rdata = ctl_reg.dst;
         OFS_OFFSET:     ctl_next.rdata = ctl_reg.offset;
         OFS_CHAN_CTRL:  ctl_next.rdata = {27'h0, ctl_reg.block_mode,
                                           ctl_reg.acc_size,
                                           ctl_reg.end_flag,
                                           ctl_reg.enable};
         OFS_BLOCK_SIZE: ctl_next.rdata = {16'h0000, ctl_reg.block_size};
         default:        ctl_next.rdata = 32'h0000_0000;
      endcase
      if (bus_wr) begin
         case (wb_adr_i)
            OFS_ADDR_CTRL: begin
               wmerge = merge(ctl_reg.addr_ctrl, wb_dat_i, wb_sel_i);
               // RULE_03 reserved writes dropped
               ctl_next.addr_ctrl = wmerge & ADDR_CTRL_WMASK;
            end
            OFS_SRC_ADDR: begin
               ctl_next.src = merge(ctl_reg.src, wb_dat_i, wb_sel_i);
            end
            OFS_DST_ADDR: begin
               ctl_next.dst = merge(ctl_reg.dst, wb_dat_i, wb_sel_i);
            end
            OFS_OFFSET: begin
               ctl_next.offset = merge(ctl_reg.offset, wb_dat_i, wb_sel_i);
            end
            OFS_CHAN_CTRL: begin
               if (wb_sel_i[0]) begin
                  // RULE_12 resume keeps addresses
                  ctl_next.enable     = wb_dat_i[POS_ENABLE];
                  ctl_next.acc_size   = wb_dat_i[POS_ACC_SIZE +: 2];
                  ctl_next.block_mode = wb_dat_i[POS_BLOCK_MODE];
                  // Flag clears by writing one
                  if (wb_dat_i[POS_END_FLAG]) begin
                     ctl_next.end_flag = 1'b0;
                  end
               end
            end
            OFS_BLOCK_SIZE: begin
               wmerge = merge({16'h0000, ctl_reg.block_size}, wb_dat_i,
                              wb_sel_i);
               ctl_next.block_size = wmerge[15:0];
            end
            default: begin
               wmerge = 32'h0000_0000;
            end
         endcase
      end
      // Channel state; a halt beats a same-cycle software enable
      case (ctl_reg.state)
         ST_IDLE: begin
            if (ctl_reg.enable) begin
               ctl_next.state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (ovf_irq && ctl_reg.block_mode && !block_end) begin
               ctl_next.state = ST_DEFER;
            end
         end
         ST_DEFER: begin
            ctl_next.state = ST_DEFER;
         end
         default: begin
            ctl_next.state = ST_IDLE;
         end
      endcase
      if (!ctl_next.enable) begin
         ctl_next.state = ST_IDLE;
      end
      if (stop) begin
         ctl_next.enable   = 1'b0;
         ctl_next.end_flag = 1'b1;
         ctl_next.state    = ST_IDLE;
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctl_reg            <= '0;
         ctl_reg.addr_ctrl  <= RST_WORD;
         ctl_reg.block_size <= RST_BLOCK;
         ctl_reg.state      <= ST_IDLE;
      end else begin
         ctl_reg <= ctl_next;
      end
   end

   assign wb_ack_o     = ctl_reg.ack;
   assign wb_dat_o     = ctl_reg.rdata;
   assign end_status_o = ctl_reg.end_flag;

   // A stalled receiver fills the buffer and stops address updates
   rec_buffer #(
      .W (REC_W)
   ) rec_buffer_i (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (push),
      .in_ready_o  (buf_ready),
      .in_data_i   ({ctl_reg.src, ctl_reg.dst, ctl_reg.acc_size}),
      .out_valid_o (xfer_valid_o),
      .out_ready_i (xfer_ready_i),
      .out_data_o  (rec_out)
   );
   assign xfer_src_o  = rec_out[65:34];
   assign xfer_dst_o  = rec_out[33:2];
   assign xfer_size_o = rec_out[1:0];

   a_rsvd_read_zero: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_03
      $past(bus_req && wb_adr_i == OFS_ADDR_CTRL) |->
         (wb_dat_o & ADDR_CTRL_RSVD) == 32'h0000_0000)
      else $error("reserved control bits read nonzero");
   a_src_fixed_mode: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_04
      push && src_mode == UPD_FIXED && !bus_wr |=>
         ctl_reg.src == $past(ctl_reg.src))
      else $error("fixed source address moved");
   a_src_offset_add: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_17
      push && src_active && src_mode == UPD_OFFSET && !area_set
         && !bus_wr |=>
         ctl_reg.src == $past(ctl_reg.src) + $past(ctl_reg.offset))
      else $error("source offset add wrong");
   a_src_inc_long: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_05
      push && src_active && src_mode == UPD_INC && !area_set
         && ctl_reg.acc_size == SIZE_LONG && !bus_wr |=>
         ctl_reg.src == $past(ctl_reg.src) + 32'h0000_0004)
      else $error("source longword increment wrong");
   a_src_dec_byte: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_05
      push && src_active && src_mode == UPD_DEC && !area_set
         && ctl_reg.acc_size == SIZE_BYTE && !bus_wr |=>
         ctl_reg.src == $past(ctl_reg.src) - 32'h0000_0001)
      else $error("source byte decrement wrong");
   a_src_single_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_06
      push && single_mode && direction && !bus_wr |=>
         $stable(ctl_reg.src))
      else $error("unselected source address moved");
   a_dst_inc_word: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_08
      push && dst_active && dst_mode == UPD_INC
         && ctl_reg.acc_size == SIZE_WORD && !bus_wr |=>
         ctl_reg.dst == $past(ctl_reg.dst) + 32'h0000_0002)
      else $error("destination word increment wrong");
   a_dst_fixed_mode: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_07
      push && dst_mode == UPD_FIXED && !bus_wr |=> $stable(ctl_reg.dst))
      else $error("fixed destination address moved");
   a_dst_single_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_09
      push && single_mode && !direction && !bus_wr |=>
         $stable(ctl_reg.dst))
      else $error("unselected destination address moved");
   a_ovf_halts_chan: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_10
      ovf_irq && !ctl_reg.block_mode |=>
         !ctl_reg.enable && ctl_reg.end_flag)
      else $error("overflow did not halt channel");
   a_ovf_block_defer: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_11
      ovf_irq && ctl_reg.block_mode && !block_end && !bus_wr |=>
         ctl_reg.enable && ctl_reg.state == ST_DEFER)
      else $error("block overflow halted early");
   a_no_area_runs: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_13
      push && !area_set && ctl_reg.state == ST_RUN && !block_end
         && !bus_wr |=> ctl_reg.enable)
      else $error("channel halted without an area");
   a_area_upper_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_15
      push && area_set && src_active && !bus_wr |=>
         (ctl_reg.src & ~$past(src_mask))
            == ($past(ctl_reg.src) & ~$past(src_mask)))
      else $error("area upper source bits changed");
   a_resume_keeps: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_12
      $rose(ctl_reg.enable) |-> $stable(ctl_reg.src) && $stable(ctl_reg.dst))
      else $error("resume changed addresses");
   a_area_decode: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_01
      dst_block_area_o |-> area_sel == AREA_DST && !src_block_area_o)
      else $error("area select decode wrong");
endmodule : dma_address_update_control

// >>> tb/xfer_sink.sv
// Receiver of the access stream that can stall and records what it takes
`timescale 1ns/100ps
module xfer_sink (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        stall_i,
   input  wire logic        valid_i,
   input  wire logic [31:0] src_i,
   input  wire logic [31:0] dst_i,
   input  wire logic [1:0]  size_i,
   output logic             ready_o
);
   logic [31:0] qs[$];
   logic [31:0] qd[$];
   logic [1:0]  qz[$];
   // Ready drops at once when stalled, like a busy bus target
   assign ready_o = !stall_i;
   // A record counts only at an edge with valid and ready both high
   always @(posedge clk_i) begin
      if (!rst_i && valid_i && ready_o) begin
         qs.push_back(src_i);
         qd.push_back(dst_i);
         qz.push_back(size_i);
      end
   end
endmodule : xfer_sink

// >>> tb/dma_address_update_control_bench.sv
// Self-checking bench for the address update control block
`timescale 1ns/100ps
module dma_address_update_control_bench;
   import dma_addr_pkg::*;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, rdy, stall = 0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, src, dst;
   logic ack, vld, sba, dba, es;
   logic [1:0] sz;
   int error_cnt = 0, samples_checked = 0;
   always #5 clk_i = ~clk_i;
   dma_address_update_control dma_address_update_control_i (.clk_i(clk_i),
      .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .xfer_valid_o(vld), .xfer_ready_i(rdy),
      .xfer_src_o(src), .xfer_dst_o(dst), .xfer_size_o(sz),
      .src_block_area_o(sba), .dst_block_area_o(dba), .end_status_o(es));
   xfer_sink xfer_sink_i (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall),
      .valid_i(vld), .src_i(src), .dst_i(dst), .size_i(sz), .ready_o(rdy));
   // One comparison, counted and reported
   task automatic chk(input string n, input logic [31:0] s, e);
      samples_checked++;
      if (s !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic print_verdict;
      $display("errors %0d checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : print_verdict
   // Classic single cycle: hold everything until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
      do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
      if (n >= 50) chk("ack", 0, 1);
      q = rdat;
      cyc <= 0; stb <= 0; we <= 0;
   endtask : wb
   function automatic logic [31:0] dlt(int m, int s);
      return m == 1 ? 32'h10 : m == 2 ? 32'h1 << s : m == 3 ? -(32'h1 << s) : 0;
   endfunction : dlt
   // Fill the stalled buffer, try a resume, then drain and judge 2 records
   task automatic run(input logic [31:0] ac, sa, input logic [1:0] z,
                      input logic [1:0] ecc, input logic [31:0] es1, ed1);
      logic [31:0] q;
      int n;
      stall <= 1;
      xfer_sink_i.qs.delete(); xfer_sink_i.qd.delete(); xfer_sink_i.qz.delete();
      wb(1, OFS_ADDR_CTRL, ac, q); wb(1, OFS_SRC_ADDR, sa, q);
      wb(1, OFS_DST_ADDR, 32'h200, q); wb(1, OFS_OFFSET, 32'h10, q);
      wb(1, OFS_CHAN_CTRL, 32'h1 | (z << 2), q);
      repeat (10) @(posedge clk_i);
      wb(0, OFS_CHAN_CTRL, 0, q);
      chk("enable end", q[1:0], ecc);
      chk("end out", es, ecc[1]);
      wb(1, OFS_CHAN_CTRL, 32'h3 | (z << 2), q);
      repeat (10) @(posedge clk_i);
      wb(1, OFS_CHAN_CTRL, 32'h2, q);
      stall <= 0;
      n = 0;
      while (xfer_sink_i.qs.size() < 2 && n < 50) begin @(posedge clk_i); n++; end
      if (xfer_sink_i.qs.size() < 2) chk("records", 0, 1);
      else begin
         chk("src0", xfer_sink_i.qs[0], sa);
         chk("dst0", xfer_sink_i.qd[0], 32'h200);
         chk("size0", xfer_sink_i.qz[0], z);
         chk("src1", xfer_sink_i.qs[1], es1);
         chk("dst1", xfer_sink_i.qd[1], ed1);
      end
   endtask : run
   task automatic s_regs;
      logic [31:0] q;
      wb(0, OFS_ADDR_CTRL, 0, q);
      chk("ctrl reset", q, RST_WORD);
      chk("area reset", {sba, dba}, 2'b10); // source area at reset
      wb(1, OFS_ADDR_CTRL, 32'hffff_ffff, q); wb(0, OFS_ADDR_CTRL, 0, q);
      chk("ctrl mask", q, ADDR_CTRL_WMASK);
      wb(1, 8'h20, 32'hffff_ffff, q); wb(0, 8'h20, 0, q);
      chk("unmapped", q, 0);
      for (int a = 0; a < 4; a++) begin
         wb(1, OFS_ADDR_CTRL, a << POS_AREA_SEL, q);
         chk("area out", {sba, dba}, a == 0 ? 2'b10 : a == 1 ? 2'b01 : 0);
      end
   endtask : s_regs
   // Every update mode on both sides, every access size
   task automatic s_modes;
      for (int m = 0; m < 4; m++)
         run((2 << POS_AREA_SEL) | (m << POS_SRC_MODE) | ((3 - m) << POS_DST_MODE),
             32'h100, m % 3, 2'b01, 32'h100 + dlt(m, m % 3),
             32'h200 + dlt(3 - m, m % 3));
   endtask : s_modes
   // Source area overflow: enabled, disabled, no area configured
   task automatic s_ovf;
      for (int k = 0; k < 3; k++)
         run((2 << POS_AREA_SEL) | (UPD_INC << POS_SRC_MODE) |
             ((k != 1) << POS_SRC_OVF_IE) | ((k != 2) << POS_SRC_AREA), 32'h3,
             SIZE_BYTE, k == 0 ? 2'b10 : 2'b01, k == 2 ? 32'h4 : 32'h0,
             32'h200);
   endtask : s_ovf
   // Single mode: direction picks which address moves
   task automatic s_single;
      for (int d = 0; d < 2; d++)
         run((1 << POS_SINGLE_MODE) | (d << POS_DIRECTION) | (2 << POS_AREA_SEL) |
             (UPD_INC << POS_SRC_MODE) | (UPD_INC << POS_DST_MODE), 32'h100,
             SIZE_BYTE, 2'b01, 32'h100 + (d == 0), 32'h200 + d);
   endtask : s_single
   // Block of 4 overflowing on its 2nd access halts only at block end
   task automatic s_block;
      logic [31:0] q;
      stall <= 0;
      xfer_sink_i.qs.delete();
      wb(1, OFS_ADDR_CTRL, (2 << POS_AREA_SEL) | (UPD_INC << POS_SRC_MODE) |
         (1 << POS_SRC_OVF_IE) | (1 << POS_SRC_AREA), q);
      wb(1, OFS_SRC_ADDR, 32'h2, q);
      wb(1, OFS_BLOCK_SIZE, 32'h4, q);
      // Second pass resumes from where the first one halted
      for (int r = 1; r < 3; r++) begin
         wb(1, OFS_CHAN_CTRL, 32'h13, q);
         repeat (20) @(posedge clk_i);
         wb(0, OFS_CHAN_CTRL, 0, q);
         chk("block stop", q[1:0], 2'b10);
         chk("block recs", xfer_sink_i.qs.size(), 4 * r);
      end
      for (int i = 0; i < 8; i++)
         chk("block src", xfer_sink_i.qs[i], (i + 2) % 4);
      wb(1, OFS_CHAN_CTRL, 32'h2, q);
   endtask : s_block
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 0;
      s_regs;
      s_modes;
      s_ovf;
      s_single;
      s_block;
      print_verdict;
   end
   // Whole run needs a few hundred cycles
   initial begin
      #200000;
      error_cnt++;
      print_verdict;
   end
endmodule : dma_address_update_control_bench
